/* dot_map.svh */
// Register offsets, field positions, reset values and masks of the termination and comp block
// How it works
// - Comp enable bit allows blocking windows and update pulses; clear opens no new window.
// - Each comp window blocks every command for the length field in clocks.
// - Data-path comp update pulses on the last clock of the blocking window.
// - Command-path comp update pulses at command-delay clocks after window start.
// - Windows recur every interval field plus one refresh intervals.
// - All termination timing fields count memory clocks.
// - Controller termination asserts after its delay field following a read CAS.
// - Controller termination stays on for its duration field.
// - DRAM termination asserts after read delay field following a read CAS.
// - Read DRAM termination stays on for the read duration field.
// - Write DRAM termination stays on for the write duration field.
// - Write DRAM termination follows the write delay field, normally zero.
// - Write-termination debug bit also drives controller termination on writes.
// - Force bit holds controller termination on regardless of traffic.
// - Per-rank force bit n holds rank n termination pin on.
// - Reads of ranks 0 to 3 drive that rank's byte of the low matrix.
// - Reads of ranks 4 to 7 drive that rank's byte of the high matrix.
`ifndef DOT_MAP_SVH
`define DOT_MAP_SVH

`define DOT_OFF_COMP 8'h98
`define DOT_OFF_TIMING 8'h9C
`define DOT_OFF_FORCE 8'hA0
`define DOT_OFF_RD_LOW 8'hA4
`define DOT_OFF_RD_HIGH 8'hA8

`define DOT_RST_COMP 32'h0001_0890
`define DOT_RST_TIMING 32'h0064_5050
`define DOT_RST_FORCE 32'h0000_0000
`define DOT_RST_RD_MATRIX 32'h0101_0404

`define DOT_MASK_COMP 32'h0001_FFFF
`define DOT_MASK_TIMING 32'h07FF_FFFF
`define DOT_MASK_FORCE 32'h0000_03FF

`define DOT_COMP_EN 16
`define DOT_COMP_CMD_HI 15
`define DOT_COMP_CMD_LO 10
`define DOT_COMP_LEN_HI 9
`define DOT_COMP_LEN_LO 4
`define DOT_COMP_INT_HI 3
`define DOT_COMP_INT_LO 0

`define DOT_TOFF_HI 26
`define DOT_TOFF_LO 24
`define DOT_CT_DUR_HI 23
`define DOT_CT_DUR_LO 20
`define DOT_CT_DLY_HI 19
`define DOT_CT_DLY_LO 16
`define DOT_RD_DUR_HI 15
`define DOT_RD_DUR_LO 12
`define DOT_RD_DLY_HI 11
`define DOT_RD_DLY_LO 8
`define DOT_WR_DUR_HI 7
`define DOT_WR_DUR_LO 4
`define DOT_WR_DLY_HI 3
`define DOT_WR_DLY_LO 0

`define DOT_CT_ON_WRITES 9
`define DOT_CT_FORCE 8
`define DOT_RANK_FORCE_HI 7
`define DOT_RANK_FORCE_LO 0

`endif

/* dot_pkg.sv */
// Types shared by the termination and comp block
package dot_pkg;
	typedef struct packed {
		logic rd;
		logic wr;
		logic [7:0] addr;
		logic [31:0] wdata;
	} dot_cfg_req_t;

	typedef struct packed {
		logic rd_cas;
		logic wr_cas;
		logic [2:0] rank;
		logic [7:0] wr_pattern;
	} dot_cmd_t;

	typedef enum logic [0:0] {
		DOT_COMP_IDLE = 1'b0,
		DOT_COMP_BLOCK = 1'b1
	} dot_comp_state_t;
endpackage

/* dot_rank_model.sv */
// Behavioural DRAM rank set that counts cycles with any termination pin on
`timescale 1ns/100ps
module dot_rank_model (
	input wire logic clk_sys,
	input wire logic clr,
	input wire logic [7:0] rank_odt,
	output int on_cycles
);
	// Ranks only sink termination, so nothing is driven back to the block
	always @(posedge clk_sys) begin
		if (clr) on_cycles <= 0;
		else if (rank_odt != 8'h00) on_cycles <= on_cycles + 1;
	end
endmodule

/* dot_term_comp.sv */
// Impedance-compensation windows and termination control for one memory channel
`timescale 1ns/100ps
`include "dot_map.svh"
module dot_term_comp
	import dot_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire dot_cfg_req_t cfg_req,
	output logic [31:0] cfg_rdata,
	output logic cfg_rvalid,
	input wire dot_cmd_t cmd,
	input wire logic refresh_tick,
	output logic cmd_block,
	output logic comp_cmd_update,
	output logic comp_data_update,
	output logic ctrl_term,
	output logic [7:0] rank_odt
);
	logic [31:0] comp_reg;
	logic [31:0] timing_reg;
	logic [31:0] force_reg;
	logic [31:0] rd_low_reg;
	logic [31:0] rd_high_reg;

	function automatic logic [7:0] byte_of(input logic [31:0] word, input logic [1:0] idx);
		byte_of = word[{idx, 3'b000} +: 8];
	endfunction

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
		input logic [31:0] mask);
		merge = (old & ~mask) | (wd & mask);
	endfunction

	// Register decode
	wire hit_comp = cfg_req.addr == `DOT_OFF_COMP;
	wire hit_timing = cfg_req.addr == `DOT_OFF_TIMING;
	wire hit_force = cfg_req.addr == `DOT_OFF_FORCE;
	wire hit_rd_low = cfg_req.addr == `DOT_OFF_RD_LOW;
	wire hit_rd_high = cfg_req.addr == `DOT_OFF_RD_HIGH;
	wire [31:0] rd_mux = hit_comp ? comp_reg :
		hit_timing ? timing_reg :
		hit_force ? force_reg :
		hit_rd_low ? rd_low_reg :
		hit_rd_high ? rd_high_reg : 32'h0000_0000;

	// One write strobe per register keeps each register process small
	wire we_comp = cfg_req.wr & hit_comp;
	wire we_timing = cfg_req.wr & hit_timing;
	wire we_force = cfg_req.wr & hit_force;
	wire we_rd_low = cfg_req.wr & hit_rd_low;
	wire we_rd_high = cfg_req.wr & hit_rd_high;

	// Reserved bits are masked so they always read back as zero
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			comp_reg <= `DOT_RST_COMP;
		end else if (we_comp) begin
			comp_reg <= merge(comp_reg, cfg_req.wdata, `DOT_MASK_COMP);
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			timing_reg <= `DOT_RST_TIMING;
		end else if (we_timing) begin
			timing_reg <= merge(timing_reg, cfg_req.wdata, `DOT_MASK_TIMING);
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			force_reg <= `DOT_RST_FORCE;
		end else if (we_force) begin
			force_reg <= merge(force_reg, cfg_req.wdata, `DOT_MASK_FORCE);
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			rd_low_reg <= `DOT_RST_RD_MATRIX;
		end else if (we_rd_low) begin
			rd_low_reg <= cfg_req.wdata;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			rd_high_reg <= `DOT_RST_RD_MATRIX;
		end else if (we_rd_high) begin
			rd_high_reg <= cfg_req.wdata;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			cfg_rdata <= 32'h0000_0000;
			cfg_rvalid <= 1'b0;
		end else begin
			cfg_rdata <= cfg_req.rd ? rd_mux : 32'h0000_0000;
			cfg_rvalid <= cfg_req.rd;
		end
	end

	// Compensation fields
	wire comp_en = comp_reg[`DOT_COMP_EN];
	wire [5:0] comp_cmd_delay = comp_reg[`DOT_COMP_CMD_HI:`DOT_COMP_CMD_LO];
	wire [5:0] comp_len = comp_reg[`DOT_COMP_LEN_HI:`DOT_COMP_LEN_LO];
	wire [3:0] comp_interval = comp_reg[`DOT_COMP_INT_HI:`DOT_COMP_INT_LO];

	dot_comp_state_t comp_state;
	dot_comp_state_t next_comp_state;
	logic [3:0] ref_cnt;
	logic [5:0] blk_cnt;
	logic [3:0] next_ref_cnt;
	logic [5:0] next_blk_cnt;

	// Interval counts refresh ticks; value v gives v+1 intervals
	wire interval_done = comp_en & refresh_tick & (ref_cnt == comp_interval);
	// A zero length would make an empty window, so none is opened
	wire window_start = (comp_state == DOT_COMP_IDLE) & interval_done & (comp_len != 6'h00);
	wire window_last = (comp_state == DOT_COMP_BLOCK) & (blk_cnt == comp_len - 6'h01);

	assign next_ref_cnt = !comp_en ? 4'h0 :
		!refresh_tick ? ref_cnt :
		interval_done ? 4'h0 : ref_cnt + 4'h1;

	always_comb begin
		next_comp_state = comp_state;
		next_blk_cnt = blk_cnt;
		unique case (comp_state)
			DOT_COMP_IDLE: begin
				if (window_start) begin
					next_comp_state = DOT_COMP_BLOCK;
					next_blk_cnt = 6'h00;
				end
			end
			DOT_COMP_BLOCK: begin
				// A window already open runs to its end even if the enable drops
				if (window_last) begin
					next_comp_state = DOT_COMP_IDLE;
				end else begin
					next_blk_cnt = blk_cnt + 6'h01;
				end
			end
		endcase
	end

	wire next_in_block = next_comp_state == DOT_COMP_BLOCK;
	wire next_data_upd = next_in_block & (next_blk_cnt == comp_len - 6'h01);
	wire next_cmd_upd = next_in_block & (next_blk_cnt == comp_cmd_delay) &
		(comp_state == DOT_COMP_IDLE || next_blk_cnt != blk_cnt);

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			comp_state <= DOT_COMP_IDLE;
			ref_cnt <= 4'h0;
			blk_cnt <= 6'h00;
		end else begin
			comp_state <= next_comp_state;
			ref_cnt <= next_ref_cnt;
			blk_cnt <= next_blk_cnt;
		end
	end

	// Outputs are registered from the next-state terms so they line up with the window
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			cmd_block <= 1'b0;
			comp_cmd_update <= 1'b0;
			comp_data_update <= 1'b0;
		end else begin
			cmd_block <= next_in_block;
			comp_cmd_update <= next_cmd_upd;
			comp_data_update <= next_data_upd;
		end
	end

	// Termination timing fields in memory clocks, then the force and write-termination bits
	wire [3:0] ct_dur = timing_reg[`DOT_CT_DUR_HI:`DOT_CT_DUR_LO];
	wire [3:0] ct_dly = timing_reg[`DOT_CT_DLY_HI:`DOT_CT_DLY_LO];
	wire [3:0] rd_dur = timing_reg[`DOT_RD_DUR_HI:`DOT_RD_DUR_LO];
	wire [3:0] rd_dly = timing_reg[`DOT_RD_DLY_HI:`DOT_RD_DLY_LO];
	wire [3:0] wr_dur = timing_reg[`DOT_WR_DUR_HI:`DOT_WR_DUR_LO];
	wire [3:0] wr_dly = timing_reg[`DOT_WR_DLY_HI:`DOT_WR_DLY_LO];
	wire ct_on_writes = force_reg[`DOT_CT_ON_WRITES];
	wire ct_force = force_reg[`DOT_CT_FORCE];
	wire [7:0] rank_force = force_reg[`DOT_RANK_FORCE_HI:`DOT_RANK_FORCE_LO];

	wire ct_start = cmd.rd_cas | (cmd.wr_cas & ct_on_writes);
	wire [7:0] rd_sel = cmd.rank[2] ? byte_of(rd_high_reg, cmd.rank[1:0]) :
		byte_of(rd_low_reg, cmd.rank[1:0]);

	logic [7:0] rd_pattern;
	logic [7:0] wr_pattern;
	logic ct_win;
	logic rd_win;
	logic wr_win;

	// Pattern is latched at CAS so only a later CAS of the same kind can alter a live window
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			rd_pattern <= 8'h00;
		end else if (cmd.rd_cas) begin
			rd_pattern <= rd_sel;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			wr_pattern <= 8'h00;
		end else if (cmd.wr_cas) begin
			wr_pattern <= cmd.wr_pattern;
		end
	end

	dot_term_timer u_ct_timer (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.start(ct_start),
		.delay(ct_dly),
		.duration(ct_dur),
		.active(ct_win)
	);

	dot_term_timer u_rd_timer (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.start(cmd.rd_cas),
		.delay(rd_dly),
		.duration(rd_dur),
		.active(rd_win)
	);

	dot_term_timer u_wr_timer (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.start(cmd.wr_cas),
		.delay(wr_dly),
		.duration(wr_dur),
		.active(wr_win)
	);

	wire next_ct = ct_force | ct_win;
	wire [7:0] next_odt = rank_force |
		(rd_win ? rd_pattern : 8'h00) | (wr_win ? wr_pattern : 8'h00);

	// Force bits pass through the same flop, so they take effect one clock after the write
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_term <= 1'b0;
		end else begin
			ctrl_term <= next_ct;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			rank_odt <= 8'h00;
		end else begin
			rank_odt <= next_odt;
		end
	end
endmodule

/* dot_term_comp_sva.sv */
// Port checker for the comp window and termination block
`timescale 1ns/100ps
module dot_term_comp_sva
	import dot_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire dot_cfg_req_t cfg_req,
	input wire logic [31:0] cfg_rdata,
	input wire logic cfg_rvalid,
	input wire dot_cmd_t cmd,
	input wire logic refresh_tick,
	input wire logic cmd_block,
	input wire logic comp_cmd_update,
	input wire logic comp_data_update,
	input wire logic ctrl_term,
	input wire logic [7:0] rank_odt
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	logic [5:0] blk_cnt;
	logic [4:0] quiet;
	// Quiet saturates so a long idle spell never wraps into a false cause
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			blk_cnt <= 6'h00;
			quiet <= 5'h1F;
		end else begin
			blk_cnt <= cmd_block ? blk_cnt + 6'h01 : 6'h00;
			quiet <= (cmd.rd_cas || cmd.wr_cas || cfg_req.wr) ? 5'h00 : quiet + {4'h0, quiet != 5'h1F};
		end
	end
	sequence win_end;
		cmd_block ##1 !cmd_block;
	endsequence
	block_cause_a: assert property ($rose(cmd_block) |-> $past(refresh_tick))
		else $error("window without tick");
	block_len_a: assert property (cmd_block |-> blk_cnt < 6'h3F)
		else $error("window too long");
	data_last_a: assert property (comp_data_update |-> win_end)
		else $error("data update not last");
	data_end_a: assert property ($fell(cmd_block) |-> $past(comp_data_update))
		else $error("window ended without data update");
	cmd_inside_a: assert property (comp_cmd_update |-> cmd_block ##1 !comp_cmd_update)
		else $error("cmd update outside window");
	idle_quiet_a: assert property (!cmd_block |-> !comp_cmd_update && !comp_data_update)
		else $error("update while idle");
	ctrl_cause_a: assert property ($rose(ctrl_term) |-> quiet <= 5'h10)
		else $error("ctrl term without cause");
	odt_cause_a: assert property (|(rank_odt & ~$past(rank_odt)) |-> quiet <= 5'h10)
		else $error("rank odt without cause");
endmodule
bind dot_term_comp dot_term_comp_sva chk_u (.clk_sys(clk_sys), .rst_n(rst_n), .cfg_req(cfg_req),
	.cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid), .cmd(cmd), .refresh_tick(refresh_tick),
	.cmd_block(cmd_block), .comp_cmd_update(comp_cmd_update),
	.comp_data_update(comp_data_update), .ctrl_term(ctrl_term), .rank_odt(rank_odt));

/* dot_term_timer.sv */
// Delay-then-duration window timer for one termination enable
`timescale 1ns/100ps
module dot_term_timer
	import dot_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic start,
	input wire logic [3:0] delay,
	input wire logic [3:0] duration,
	output logic active
);
	logic armed;
	logic [4:0] cnt;
	logic [4:0] last;
	logic next_armed;
	logic [4:0] next_cnt;
	logic next_active;

	// A new CAS restarts the window; back-to-back bursts extend it only when the delay is zero, otherwise it drops for the delay
	assign last = {1'b0, delay} + {1'b0, duration};
	assign next_cnt = start ? 5'h00 : (armed ? cnt + 5'h01 : cnt);
	assign next_armed = start | (armed & (cnt + 5'h01 < last));
	assign next_active = next_armed & (next_cnt >= {1'b0, delay}) & (next_cnt < last);

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			armed <= 1'b0;
			cnt <= 5'h00;
			active <= 1'b0;
		end else begin
			armed <= next_armed;
			cnt <= next_cnt;
			active <= next_active;
		end
	end
endmodule

/* tb_ddr3_odt_and_rcomp_timing.sv */
// Self-checking bench for the comp window and termination block
`timescale 1ns/100ps
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin fails++; $display("[FAIL] %s exp %h got %h", n, e, g); end end
module tb_ddr3_odt_and_rcomp_timing;
	import dot_pkg::*;
	logic clk_sys = 0, rst_n = 0, refresh_tick = 0, clr = 0;
	dot_cfg_req_t cfg_req = '0;
	dot_cmd_t cmd = '0;
	logic [31:0] cfg_rdata;
	logic cfg_rvalid, cmd_block, comp_cmd_update, comp_data_update, ctrl_term;
	logic [7:0] rank_odt;
	int fails = 0, checks_done = 0, on_cycles;
	logic [31:0] m [int];
	logic [31:0] msk [int];
	dot_term_comp dut_u (.clk_sys(clk_sys), .rst_n(rst_n), .cfg_req(cfg_req),
		.cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid), .cmd(cmd), .refresh_tick(refresh_tick),
		.cmd_block(cmd_block), .comp_cmd_update(comp_cmd_update),
		.comp_data_update(comp_data_update), .ctrl_term(ctrl_term), .rank_odt(rank_odt));
	dot_rank_model ranks_u (.clk_sys(clk_sys), .clr(clr), .rank_odt(rank_odt), .on_cycles(on_cycles));
	initial forever #4 clk_sys = ~clk_sys;
	task close_out;
		if (fails == 0 && checks_done > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	task wr(input int a, input logic [31:0] d);
		@(negedge clk_sys);
		cfg_req.wr = 1;
		cfg_req.addr = a[7:0];
		cfg_req.wdata = d;
		if (msk.exists(a)) m[a] = d & msk[a];
		@(negedge clk_sys);
		cfg_req.wr = 0;
	endtask
	task rd(input int a);
		logic [31:0] e;
		e = m.exists(a) ? m[a] : 32'h0;
		@(negedge clk_sys);
		cfg_req.rd = 1;
		cfg_req.addr = a[7:0];
		@(negedge clk_sys);
		cfg_req.rd = 0;
		`CHK("rvalid", 1'b1, cfg_rvalid)
		`CHK("rdata", e, cfg_rdata)
	endtask
	// Timing fields are kept at 7 or less so the whole window fits the loop
	task term(input logic rdc, input logic [2:0] rk, input logic [7:0] wp);
		logic [31:0] t;
		logic [7:0] pat;
		int d, n, cd, cn;
		t = m['h9C];
		d = rdc ? t[11:8] : t[3:0];
		n = rdc ? t[15:12] : t[7:4];
		cd = t[19:16];
		cn = (rdc || m['hA0][9]) ? t[23:20] : 0;
		pat = rdc ? 8'(m[rk < 4 ? 'hA4 : 'hA8] >> (8 * rk[1:0])) : wp;
		@(negedge clk_sys);
		cmd.rd_cas = rdc;
		cmd.wr_cas = !rdc;
		cmd.rank = rk;
		cmd.wr_pattern = wp;
		for (int k = 1; k < 20; k++) begin
			@(negedge clk_sys);
			cmd.rd_cas = 0;
			cmd.wr_cas = 0;
			`CHK("rank_odt", m['hA0][7:0] | ((k >= d + 2 && k <= d + n + 1) ? pat : 8'h00), rank_odt)
			`CHK("ctrl_term", m['hA0][8] | (k >= cd + 2 && k <= cd + cn + 1), ctrl_term)
		end
	endtask
	task tick(input int len, input int cd);
		@(negedge clk_sys);
		refresh_tick = 1;
		for (int k = 1; k <= len + 1; k++) begin
			@(negedge clk_sys);
			refresh_tick = 0;
			`CHK("cmd_block", k <= len, cmd_block)
			`CHK("cmd_update", k == cd + 1, comp_cmd_update)
			`CHK("data_update", k == len, comp_data_update)
		end
	endtask
	initial begin
		#100000;
		fails++;
		close_out;
	end
	initial begin
		m['h98] = 32'h0001_0890;
		m['h9C] = 32'h0064_5050;
		m['hA0] = 32'h0;
		m['hA4] = 32'h0101_0404;
		m['hA8] = 32'h0101_0404;
		msk['h98] = 32'h0001_FFFF;
		msk['h9C] = 32'h07FF_FFFF;
		msk['hA0] = 32'h0000_03FF;
		msk['hA4] = 32'hFFFF_FFFF;
		msk['hA8] = 32'hFFFF_FFFF;
		void'($urandom(32'h18375DB8));
		repeat (5) @(negedge clk_sys);
		rst_n = 1;
		foreach (m[a]) rd(a);
		rd('hB0);
		foreach (msk[a]) begin
			wr(a, $urandom);
			rd(a);
		end
		wr('hA0, 32'h0);
		wr('h98, 32'h0);
		for (int r = 0; r < 8; r++) begin
			wr('h9C, $urandom & 32'h0077_7770);
			term(1, r[2:0], 8'($urandom));
			term(0, r[2:0], 8'($urandom));
		end
		wr('hA0, 32'h200 | ($urandom & 32'hFF));
		term(0, 3'h5, 8'($urandom));
		term(1, 3'h2, 8'($urandom));
		wr('hA0, 32'h100);
		term(1, 3'h6, 8'h00);
		wr('hA0, 32'h0);
		clr = 1;
		@(negedge clk_sys);
		clr = 0;
		repeat (10) @(negedge clk_sys);
		`CHK("on_cycles", 0, on_cycles)
		wr('h98, 32'h0001_3DF1);
		tick(0, -5);
		tick(31, 15);
		tick(0, -5);
		tick(31, 15);
		wr('h98, 32'h0000_3DF1);
		tick(0, -5);
		tick(0, -5);
		close_out;
	end
endmodule
